/* design/daurc_top.sv */
// Two-channel converter update control with reference enables
// ============================================================================
// How it works
// - Mode 00 loads the output latch on every high byte write.
// - In mode 00 a low byte write is only stored.
// - Modes 01, 10, 11 hold byte writes until timer 3, 4, 2 overflow.
// - Selected overflow copies the stored byte pair into the output latch.
// - Three-bit format field picks one of five word orientations.
// - Second channel behaves identically with its own registers.
// - Bias enable powers the generator; buffer enable powers the pin buffer.
// - Disabled buffer leaves the reference pin undriven.
// - One select bit per ADC chooses its reference source.
`timescale 1ns/10ps
`default_nettype none

module daurc_top
  import daurc_pkg::*;
(
  input wire logic i_sys_clk, // 20 MHz system clock
  input wire logic i_sys_rst, // Async reset, active high
  input wire logic [7:0] i_wr_data, // Shared write data byte
  input wire logic [1:0] i_ctrl_wr, // Control write, per channel
  input wire logic [1:0] i_low_wr, // Low byte write, per channel
  input wire logic [1:0] i_high_wr, // High byte write, per channel
  input wire logic i_ref_wr, // Reference control write
  input wire logic i_tmr2_ovf, // Timer 2 overflow pulse
  input wire logic i_tmr3_ovf, // Timer 3 overflow pulse
  input wire logic i_tmr4_ovf, // Timer 4 overflow pulse
  output logic [11:0] o_ch0_code, // First channel output latch
  output logic [11:0] o_ch1_code, // Second channel output latch
  output logic [CTRL_W-1:0] o_ch0_ctrl, // First channel control readback
  output logic [CTRL_W-1:0] o_ch1_ctrl, // Second channel control readback
  output logic o_bias_en, // Bias generator on
  output logic o_refbuf_en, // Reference buffer on
  output logic o_ref_pin_oe, // Reference pin driven
  output logic o_adc0_ref_sel, // First ADC reference select
  output logic o_adc1_ref_sel // Second ADC reference select
);

  // ==========================================================================
  // Helpers
  function automatic logic ovf_hit(input logic [1:0] mode, input logic t2, input logic t3,
                                   input logic t4);
    logic hit;
    hit = 1'b0;
    case (daurc_mode_e'(mode))
      MODE_TMR3: hit = t3;
      MODE_TMR4: hit = t4;
      MODE_TMR2: hit = t2;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : ovf_hit

  function automatic logic [1:0] mode_of(input logic [CTRL_W-1:0] ctrl);
    return ctrl[MODE_LSB +: 2];
  endfunction : mode_of

  function automatic logic [2:0] fmt_of(input logic [CTRL_W-1:0] ctrl);
    return ctrl[FMT_LSB +: 3];
  endfunction : fmt_of

  // ==========================================================================
  // State
  daurc_top_s st_ff;
  daurc_top_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    for (int c = 0; c < 2; c++) begin
      if (i_ctrl_wr[c]) begin
        nxt_st.ch[c].ctrl = i_wr_data[CTRL_W-1:0];
      end
      if (i_low_wr[c]) begin
        nxt_st.ch[c].low = i_wr_data;
      end
      if (i_high_wr[c]) begin
        nxt_st.ch[c].high = i_wr_data;
      end
      if (mode_of(st_ff.ch[c].ctrl) == MODE_DEMAND) begin
        if (i_high_wr[c]) begin
          nxt_st.ch[c].code = daurc_fmt_word({i_wr_data, st_ff.ch[c].low}, fmt_of(st_ff.ch[c].ctrl));
        end
      end else if (ovf_hit(mode_of(st_ff.ch[c].ctrl), i_tmr2_ovf, i_tmr3_ovf, i_tmr4_ovf)) begin
        nxt_st.ch[c].code = daurc_fmt_word({st_ff.ch[c].high, st_ff.ch[c].low}, fmt_of(st_ff.ch[c].ctrl));
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int c = 0; c < 2; c++) begin
        st_ff.ch[c] <= '{CTRL_RST, BYTE_RST, BYTE_RST, CODE_RST};
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_ch0_code = st_ff.ch[0].code;
  assign o_ch1_code = st_ff.ch[1].code;
  assign o_ch0_ctrl = st_ff.ch[0].ctrl;
  assign o_ch1_ctrl = st_ff.ch[1].ctrl;

  daurc_ref_ctrl u_ref (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_ref_wr(i_ref_wr),
    .i_wr_data(i_wr_data),
    .o_bias_en(o_bias_en),
    .o_refbuf_en(o_refbuf_en),
    .o_ref_pin_oe(o_ref_pin_oe),
    .o_adc0_ref_sel(o_adc0_ref_sel),
    .o_adc1_ref_sel(o_adc1_ref_sel)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic [1:0] m0;
  logic [1:0] m1;
  logic [2:0] f0;
  assign m0 = mode_of(st_ff.ch[0].ctrl);
  assign m1 = mode_of(st_ff.ch[1].ctrl);
  assign f0 = fmt_of(st_ff.ch[0].ctrl);

  property p_demand_load;
    logic [15:0] pr;
    logic [2:0] f;
    (m0 == MODE_DEMAND && i_high_wr[0], pr = {i_wr_data, st_ff.ch[0].low}, f = f0)
      |=> o_ch0_code == daurc_fmt_word(pr, f);
  endproperty
  a_demand_load: assert property (p_demand_load) else $error("ch0 high write did not load latch");

  property p_low_held;
    (m0 == MODE_DEMAND && i_low_wr[0] && !i_high_wr[0]) |=> $stable(o_ch0_code);
  endproperty
  a_low_held: assert property (p_low_held) else $error("ch0 low write moved output");

  property p_timer_hold;
    (m0 != MODE_DEMAND && !ovf_hit(m0, i_tmr2_ovf, i_tmr3_ovf, i_tmr4_ovf)) |=> $stable(o_ch0_code);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("ch0 output moved without overflow");

  property p_tmr3_copy;
    logic [15:0] pr;
    logic [2:0] f;
    (m0 == MODE_TMR3 && i_tmr3_ovf, pr = {st_ff.ch[0].high, st_ff.ch[0].low}, f = f0)
      |=> o_ch0_code == daurc_fmt_word(pr, f);
  endproperty
  a_tmr3_copy: assert property (p_tmr3_copy) else $error("timer 3 overflow did not copy");

  property p_fmt_left;
    logic [7:0] h;
    (m0 == MODE_DEMAND && f0 == FMT_LEFT && i_high_wr[0], h = i_wr_data)
      |=> o_ch0_code[11:4] == h;
  endproperty
  a_fmt_left: assert property (p_fmt_left) else $error("left justified word misplaced");

  property p_fmt_reserved;
    logic [7:0] l;
    (m0 == MODE_DEMAND && f0 > FMT_LEFT && i_high_wr[0] && !i_low_wr[0], l = st_ff.ch[0].low)
      |=> o_ch0_code[7:0] == l;
  endproperty
  a_fmt_reserved: assert property (p_fmt_reserved) else $error("reserved format not right justified");

  property p_ch1_demand;
    logic [15:0] pr;
    logic [2:0] f;
    (m1 == MODE_DEMAND && i_high_wr[1], pr = {i_wr_data, st_ff.ch[1].low}, f = fmt_of(st_ff.ch[1].ctrl))
      |=> o_ch1_code == daurc_fmt_word(pr, f);
  endproperty
  a_ch1_demand: assert property (p_ch1_demand) else $error("ch1 high write did not load latch");

  property p_wrong_timer;
    (m1 == MODE_TMR4 && i_tmr3_ovf && !i_tmr4_ovf) |=> $stable(o_ch1_code);
  endproperty
  a_wrong_timer: assert property (p_wrong_timer) else $error("unselected timer updated ch1");

  property p_ref_enables;
    logic b;
    logic r;
    (i_ref_wr, b = i_wr_data[REF_BIAS_BIT], r = i_wr_data[REF_BUF_BIT])
      |=> o_bias_en == b && o_refbuf_en == r ##1 o_refbuf_en == o_ref_pin_oe;
  endproperty
  a_ref_enables: assert property (p_ref_enables) else $error("reference enables wrong");

  property p_pin_release;
    !o_refbuf_en |-> !o_ref_pin_oe;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin driven with buffer off");

  property p_ref_sel;
    logic s0;
    logic s1;
    (i_ref_wr, s0 = i_wr_data[REF_SEL0_BIT], s1 = i_wr_data[REF_SEL1_BIT])
      |=> o_adc0_ref_sel == s0 && o_adc1_ref_sel == s1;
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("ADC reference select wrong");

  c_full_word: cover property (i_low_wr[0] ##1 i_high_wr[0] && m0 == MODE_DEMAND);
  c_tmr2_update: cover property (m1 == MODE_TMR2 && i_tmr2_ovf);
  c_tmr4_update: cover property (m0 == MODE_TMR4 && i_tmr4_ovf);
  c_bandgap_on: cover property (o_bias_en && o_refbuf_en);

endmodule : daurc_top

`default_nettype wire

/* design/daurc_pkg.sv */
// Shared constants, types and helpers for the converter update and reference control block
package daurc_pkg;

  // ==========================================================================
  // Converter control word layout
  localparam int CTRL_W = 5;
  localparam int MODE_LSB = 3;
  localparam int FMT_LSB = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [11:0] CODE_RST = 12'h000;

  // ==========================================================================
  // Update modes
  typedef enum logic [1:0] {
    MODE_DEMAND = 2'h0,
    MODE_TMR3 = 2'h1,
    MODE_TMR4 = 2'h2,
    MODE_TMR2 = 2'h3
  } daurc_mode_e;

  // Highest valid format code, four places of shift
  localparam logic [2:0] FMT_LEFT = 3'h4;

  // ==========================================================================
  // Reference control word layout
  localparam int REF_BUF_BIT = 0;
  localparam int REF_BIAS_BIT = 1;
  localparam int REF_SEL0_BIT = 3;
  localparam int REF_SEL1_BIT = 4;
  localparam logic REF_BIT_RST = 1'b0;

  // ==========================================================================
  // State types
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [7:0] low;
    logic [7:0] high;
    logic [11:0] code;
  } daurc_chan_s;

  typedef struct packed {
    daurc_chan_s [1:0] ch;
  } daurc_top_s;

  typedef struct packed {
    logic bias;
    logic refbuf;
    logic sel0;
    logic sel1;
  } daurc_ref_s;

  // ==========================================================================
  // Byte pair to 12-bit word; reserved codes fall back to right justified
  // reserved codes right justify
  function automatic logic [11:0] daurc_fmt_word(input logic [15:0] pair, input logic [2:0] fmt);
    logic [15:0] sh;
    sh = (fmt <= FMT_LEFT) ? (pair >> fmt) : pair;
    return sh[11:0];
  endfunction : daurc_fmt_word

endpackage : daurc_pkg

/* design/daurc_ref_ctrl.sv */
// Reference generator and reference source select register
`timescale 1ns/10ps
`default_nettype none

module daurc_ref_ctrl
  import daurc_pkg::*;
(
  input wire logic i_sys_clk, // 20 MHz system clock
  input wire logic i_sys_rst, // Async reset, active high
  input wire logic i_ref_wr, // Reference control write strobe
  input wire logic [7:0] i_wr_data, // Write data byte
  output logic o_bias_en, // Bias generator on
  output logic o_refbuf_en, // Gain-of-two buffer on
  output logic o_ref_pin_oe, // Buffer drives reference pin
  output logic o_adc0_ref_sel, // First ADC reference source
  output logic o_adc1_ref_sel // Second ADC reference source
);

  // ==========================================================================
  // State
  daurc_ref_s st_ff;
  daurc_ref_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_ref_wr) begin
      nxt_st.bias = i_wr_data[REF_BIAS_BIT];
      nxt_st.refbuf = i_wr_data[REF_BUF_BIT];
      nxt_st.sel0 = i_wr_data[REF_SEL0_BIT];
      nxt_st.sel1 = i_wr_data[REF_SEL1_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '{REF_BIT_RST, REF_BIT_RST, REF_BIT_RST, REF_BIT_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  // bias and buffer enables, pin drive and reference selects
  assign o_bias_en = st_ff.bias;
  assign o_refbuf_en = st_ff.refbuf;
  assign o_ref_pin_oe = st_ff.refbuf;
  assign o_adc0_ref_sel = st_ff.sel0;
  assign o_adc1_ref_sel = st_ff.sel1;

endmodule : daurc_ref_ctrl

`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the converter update and reference control block
`timescale 1ns/10ps
`default_nettype none

module tb;
  import daurc_pkg::*;

  // ==========================================================================
  // Clock, reset and stimulus signals
  localparam int LIMIT = 4000;
  localparam logic [7:0] REF_PAT [8] = '{8'h00, 8'h03, 8'h02, 8'h01, 8'h08, 8'h10, 8'h18, 8'hE4};
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] wdata = 8'h00;
  logic [1:0] ctrl_wr = 2'h0;
  logic [1:0] low_wr = 2'h0;
  logic [1:0] high_wr = 2'h0;
  logic ref_wr = 1'b0;
  logic [3:1] tmr = 3'h0;
  logic [11:0] ch0_code, ch1_code;
  logic [CTRL_W-1:0] ch0_ctrl, ch1_ctrl;
  logic bias_en, refbuf_en, pin_oe, sel0, sel1;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [11:0] exp_code [2];

  always #25 i_sys_clk = ~i_sys_clk;

  daurc_top uut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_wr_data(wdata),
    .i_ctrl_wr(ctrl_wr), .i_low_wr(low_wr), .i_high_wr(high_wr), .i_ref_wr(ref_wr),
    .i_tmr2_ovf(tmr[3]), .i_tmr3_ovf(tmr[1]), .i_tmr4_ovf(tmr[2]),
    .o_ch0_code(ch0_code), .o_ch1_code(ch1_code), .o_ch0_ctrl(ch0_ctrl), .o_ch1_ctrl(ch1_ctrl),
    .o_bias_en(bias_en), .o_refbuf_en(refbuf_en), .o_ref_pin_oe(pin_oe),
    .o_adc0_ref_sel(sel0), .o_adc1_ref_sel(sel1)
  );

  // ==========================================================================
  // Access tasks
  task automatic step();
    @(posedge i_sys_clk);
    #5;
  endtask : step

  // Strobe held one cycle, then one idle cycle so no signal is set twice per step
  task automatic wr(input int kind, input int ch, input logic [7:0] d);
    wdata = d;
    case (kind)
      0: ctrl_wr[ch] = 1'b1;
      1: low_wr[ch] = 1'b1;
      2: high_wr[ch] = 1'b1;
      default: ref_wr = 1'b1;
    endcase
    step();
    ctrl_wr = 2'h0;
    low_wr = 2'h0;
    high_wr = 2'h0;
    ref_wr = 1'b0;
    step();
  endtask : wr

  task automatic pulse(input int k);
    tmr[k] = 1'b1;
    step();
    tmr = 3'h0;
    step();
  endtask : pulse

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [11:0] fmtx(input logic [7:0] h, input logic [7:0] l, input logic [2:0] f);
    logic [15:0] p;
    p = {h, l} >> ((f > 3'h4) ? 3'h0 : f);
    return p[11:0];
  endfunction : fmtx

  function automatic logic [11:0] code(input int ch);
    return ch ? ch1_code : ch0_code;
  endfunction : code

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Test sequence
  initial begin
    logic [7:0] l, h;
    repeat (16) step();
    i_sys_rst = 1'b0;
    step();
    chk("ch0_code", 12'h000, ch0_code);
    chk("ch1_code", 12'h000, ch1_code);
    chk("ctrl", 12'h000, {2'h0, ch0_ctrl, ch1_ctrl});
    chk("ref_out", 12'h000, {7'h00, bias_en, refbuf_en, pin_oe, sel0, sel1});
    exp_code[0] = 12'h000;
    exp_code[1] = 12'h000;
    wr(3, 0, 8'h02);
    chk("bias_on", 12'h002, {10'h000, bias_en, refbuf_en});
    $display("Test reset done");

    // On-demand mode, every format code, both channels
    for (int ch = 0; ch < 2; ch++) begin
      for (int f = 0; f < 8; f++) begin
        l = 8'h5A + 8'(f * 17);
        h = 8'hC3 - 8'(f);
        wr(0, ch, {5'h00, 3'(f)});
        chk("ctrl_rb", {9'h000, 3'(f)}, 12'(ch ? ch1_ctrl : ch0_ctrl));
        wr(1, ch, l);
        chk("low_held", exp_code[ch], code(ch));
        pulse(1);
        pulse(3);
        chk("ovf_ignored", exp_code[ch], code(ch));
        wr(2, ch, h);
        exp_code[ch] = fmtx(h, l, 3'(f));
        chk("demand_code", exp_code[ch], code(ch));
        chk("other_chan", exp_code[1-ch], code(1-ch));
      end
      // Eight-bit use: only the high byte changes
      wr(0, ch, 8'h04);
      wr(1, ch, 8'h00);
      for (int s = 0; s < 2; s++) begin
        h = 8'h81 - 8'(s * 3);
        wr(2, ch, h);
        exp_code[ch] = fmtx(h, 8'h00, 3'h4);
        chk("high_only", exp_code[ch], code(ch));
      end
    end
    $display("Test on-demand done");

    // Timer-driven modes
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 1; m < 4; m++) begin
        l = 8'h3C + 8'(m);
        h = 8'hF0 - 8'(m * 16);
        wr(0, ch, {3'h0, 2'(m), 3'h4});
        wr(1, ch, l);
        wr(2, ch, h);
        chk("tmr_held", exp_code[ch], code(ch));
        for (int k = 1; k < 4; k++) begin
          if (k != m) begin
            pulse(k);
          end
        end
        chk("tmr_other", exp_code[ch], code(ch));
        pulse(m);
        exp_code[ch] = fmtx(h, l, 3'h4);
        chk("tmr_code", exp_code[ch], code(ch));
      end
    end
    $display("Test timer modes done");

    // Reference control patterns
    for (int i = 0; i < 8; i++) begin
      wr(3, 0, REF_PAT[i]);
      chk("bias", {11'h000, REF_PAT[i][1]}, {11'h000, bias_en});
      chk("refbuf", {11'h000, REF_PAT[i][0]}, {11'h000, refbuf_en});
      chk("pin_oe", {11'h000, REF_PAT[i][0]}, {11'h000, pin_oe});
      chk("ref_sel", {10'h000, REF_PAT[i][3], REF_PAT[i][4]}, {10'h000, sel0, sel1});
    end
    wr(3, 0, 8'h03);
    chk("bandgap", 12'h003, {10'h000, bias_en, refbuf_en});
    $display("Test reference done");

    // Reset in mid-run clears the latches
    i_sys_rst = 1'b1;
    step();
    chk("rst_code", 12'h000, ch0_code | ch1_code);
    chk("rst_ctrl", 12'h000, {2'h0, ch0_ctrl, ch1_ctrl});
    chk("rst_ref", 12'h000, {7'h00, bias_en, refbuf_en, pin_oe, sel0, sel1});
    i_sys_rst = 1'b0;
    step();
    chk("rel_code", 12'h000, ch0_code | ch1_code);
    wr(3, 0, 8'h02);
    wr(1, 1, 8'hA5);
    wr(2, 1, 8'h3C);
    chk("rel_write", fmtx(8'h3C, 8'hA5, 3'h0), ch1_code);
    $display("Test mid-run reset done");
    print_verdict();
  end

endmodule : tb

`default_nettype wire
